// ==== rtl/error_status_and_doorbell.sv ====
// Error status words, doorbell decode and expansion port access of the disk controller.
// Assumes all inputs are synchronous to clock and fault inputs are one-cycle pulses.
`timescale 1ns/1ps

module error_status_and_doorbell
    import error_status_pkg::*;
#(
    parameter int DATA_W = error_status_pkg::XP_DATA_W,
    parameter int ADDR_W = error_status_pkg::XP_ADDR_W
) (
    // Clock and reset.
    input  wire logic                 clock,
    input  wire logic                 rstn,
    // Host wake-up port and channel control byte 0.
    input  wire logic                 wake_wr,
    input  wire logic [7:0]           wake_data,
    input  wire logic [7:0]           ccb_byte0,
    // Command from the invocation block.
    input  wire logic                 cmd_valid,
    input  wire logic [7:0]           cmd_func,
    input  wire logic                 cmd_done,
    input  wire logic                 cmd_uncorrectable,
    // Fault events.
    input  wire logic                 ram_fault,
    input  wire logic                 rom_fault,
    input  wire logic                 seek_underway_req,
    input  wire logic                 spare_flag,
    input  wire logic                 defective_spare_flag,
    input  wire logic                 unassigned_spare_access,
    input  wire logic                 end_of_media,
    input  wire logic                 sector_size_mismatch,
    input  wire logic                 diag_fault,
    input  wire logic                 no_index,
    input  wire logic                 sector_not_found,
    input  wire logic                 bad_disk_address,
    input  wire logic                 unit_not_ready,
    input  wire logic                 write_protected_write,
    input  wire logic                 data_field_code_err,
    input  wire logic                 id_field_code_err,
    input  wire logic                 rw_fault,
    input  wire logic                 positioner_fault,
    input  wire logic                 power_fault,
    input  wire logic                 speed_fault,
    input  wire logic                 cylinder_miscompare,
    input  wire logic                 seek_failure,
    // Status seen by the host.
    output logic [15:0]               hard_error_word,
    output logic [7:0]                soft_error_byte,
    output logic [7:0]                op_status,
    output logic                      host_irq,
    // Launch control.
    output run_mode_t                 run_mode,
    output logic                      fetch_invocation,
    output logic                      fetch_host_program,
    output logic                      params_in_invocation,
    output logic                      start_resident,
    // Expansion port request from the local processor.
    input  wire logic                 xp_req,
    input  wire logic                 xp_write,
    input  wire logic [ADDR_W:0]      xp_port,
    input  wire logic [DATA_W-1:0]    xp_wdata,
    output logic [DATA_W-1:0]         xp_rdata,
    output logic                      xp_ack,
    // Expansion connector pins, shared by both connectors except xb_cs, which has one chip select per connector.
    output logic [1:0]                xb_cs,
    output logic [ADDR_W-1:0]         xb_addr,
    output logic                      xb_rd,
    output logic                      xb_wr,
    output logic [DATA_W-1:0]         xb_dout,
    output logic                      xb_doe_n,
    input  wire logic [DATA_W-1:0]    xb_din
);

    // Elaboration check: the connectors carry a fixed bus shape.
    if (DATA_W != XP_DATA_W || ADDR_W != XP_ADDR_W) begin : g_bad_shape
        $error("Expansion bus must be sixteen data and three address lines.");
    end

    // Next values and decoded events of the status group.
    logic [15:0]  next_hard;
    logic [7:0]   next_soft;
    logic [7:0]   next_op_status;
    logic [15:0]  hard_events;
    logic [7:0]   soft_events;
    logic         clear_errors;
    logic         func_invalid;

    // Events fold into the words; an event in a clearing cycle survives.
    always_comb begin
        // Codes above the last firmware code are unknown, except the resident one.
        func_invalid = cmd_valid && (cmd_func > FUNC_LAST_FIRMWARE)
                       && (cmd_func != FUNC_RUN_RESIDENT);
        clear_errors = cmd_valid && (cmd_func != FUNC_XFER_STATUS);
        hard_events = HARD_RESET;
        hard_events[HE_RAM]      = ram_fault;
        hard_events[HE_ROM]      = rom_fault;
        hard_events[HE_SEEK_BSY] = seek_underway_req;
        hard_events[HE_FORMAT]   = (spare_flag && defective_spare_flag)
                                   || unassigned_spare_access;
        hard_events[HE_EOM]      = end_of_media;
        hard_events[HE_SECSIZE]  = sector_size_mismatch;
        hard_events[HE_DIAG]     = diag_fault;
        hard_events[HE_NO_INDEX] = no_index;
        hard_events[HE_BAD_CMD]  = func_invalid;
        hard_events[HE_NO_SECT]  = sector_not_found;
        hard_events[HE_BAD_ADDR] = bad_disk_address;
        hard_events[HE_NOT_RDY]  = unit_not_ready;
        hard_events[HE_WPROT]    = write_protected_write;
        soft_events = SOFT_RESET;
        soft_events[SE_DATA_ECC] = data_field_code_err;
        soft_events[SE_ID_ECC]   = id_field_code_err;
        soft_events[SE_DRIVE]    = rw_fault || positioner_fault
                                   || power_fault || speed_fault;
        soft_events[SE_CYL_MIS]  = cylinder_miscompare;
        soft_events[SE_SEEK]     = seek_failure;
        next_hard = (clear_errors ? HARD_RESET : hard_error_word) | hard_events;
        next_soft = (clear_errors ? SOFT_RESET : soft_error_byte) | soft_events;
        // Bits 0 to 2 are never set, so they read as zero.
        next_hard[2:0] = HARD_RESET[2:0];
        next_soft[2:0] = SOFT_RESET[2:0];
        next_op_status = op_status;
        if (cmd_done) begin
            next_op_status = BYTE_ZERO;
            next_op_status[OS_UNCORR] = cmd_uncorrectable;
        end
    end

    // Error words and posted status registers.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            hard_error_word <= HARD_RESET;
            soft_error_byte <= SOFT_RESET;
            op_status       <= BYTE_ZERO;
        end else begin
            hard_error_word <= next_hard;
            soft_error_byte <= next_soft;
            op_status       <= next_op_status;
        end
    end

    // Next values of the launch group.
    run_mode_t next_mode;
    logic      next_irq;
    logic      next_fetch_inv;
    logic      next_fetch_host;
    logic      next_params_inv;
    logic      next_start_res;
    logic      wake_start;

    // Doorbell decode and launch sequencing.
    // A start written outside idle is ignored rather than queued.
    always_comb begin
        wake_start      = wake_wr && (wake_data == WAKE_START);
        next_mode       = run_mode;
        next_fetch_inv  = 1'b0;
        next_fetch_host = 1'b0;
        next_start_res  = 1'b0;
        next_params_inv = params_in_invocation;
        // Completion raises the interrupt; a clear in the same cycle loses.
        next_irq = cmd_done
                   || (host_irq && !(wake_wr && wake_data == WAKE_CLEAR_IRQ));
        case (run_mode)
            MODE_IDLE: begin
                if (wake_start && ccb_byte0 == CCB_HOST_PROG) begin
                    next_mode       = MODE_HOST_PROG;
                    next_fetch_host = 1'b1;
                    next_params_inv = 1'b1;
                end else if (wake_start) begin
                    next_mode       = MODE_FIRMWARE;
                    next_fetch_inv  = 1'b1;
                    next_params_inv = 1'b0;
                end
            end
            MODE_FIRMWARE: begin
                if (cmd_valid && cmd_func == FUNC_RUN_RESIDENT) begin
                    next_mode      = MODE_RESIDENT;
                    next_start_res = 1'b1;
                end else if (cmd_done) begin
                    next_mode = MODE_IDLE;
                end
            end
            MODE_HOST_PROG,
            MODE_RESIDENT: begin
                if (cmd_done) begin
                    next_mode = MODE_IDLE;
                end
            end
            default: begin
                next_mode = MODE_IDLE;
            end
        endcase
    end

    // Launch registers.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            run_mode             <= MODE_IDLE;
            host_irq             <= 1'b0;
            fetch_invocation     <= 1'b0;
            fetch_host_program   <= 1'b0;
            params_in_invocation <= 1'b0;
            start_resident       <= 1'b0;
        end else begin
            run_mode             <= next_mode;
            host_irq             <= next_irq;
            fetch_invocation     <= next_fetch_inv;
            fetch_host_program   <= next_fetch_host;
            params_in_invocation <= next_params_inv;
            start_resident       <= next_start_res;
        end
    end

    // Next values of the expansion pin group.
    logic [1:0]          next_cs;
    logic [ADDR_W-1:0]   next_addr;
    logic                next_rd;
    logic                next_wr;
    logic [DATA_W-1:0]   next_dout;
    logic                next_doe_n;
    logic [DATA_W-1:0]   next_rdata;
    logic                next_ack;
    logic                busy;

    // Port access: strobe one cycle, then capture and acknowledge.
    // The acknowledge cycle counts as busy as well, so a caller may hold its
    // request up to the edge at which it sees the acknowledge without the
    // request being taken a second time.
    // A request that arrives while busy is ignored; callers hold it until ack.
    // Limitation: back-to-back requests are three cycles apart, not two.
    always_comb begin
        busy       = xb_rd || xb_wr || xp_ack;
        next_cs    = 2'b00;
        next_addr  = xb_addr;
        next_rd    = 1'b0;
        next_wr    = 1'b0;
        next_dout  = xb_dout;
        next_doe_n = 1'b1;
        next_rdata = xp_rdata;
        next_ack   = xb_rd || xb_wr;
        if (xb_rd) begin
            next_rdata = xb_din;
        end
        if (xp_req && !busy) begin
            next_cs[xp_port[ADDR_W]] = 1'b1;
            next_addr  = xp_port[ADDR_W-1:0];
            next_rd    = !xp_write;
            next_wr    = xp_write;
            next_dout  = xp_wdata;
            next_doe_n = !xp_write;
        end
    end

    // Expansion pin registers.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            xb_cs    <= 2'b00;
            xb_addr  <= '0;
            xb_rd    <= 1'b0;
            xb_wr    <= 1'b0;
            xb_dout  <= '0;
            xb_doe_n <= 1'b1;
            xp_rdata <= '0;
            xp_ack   <= 1'b0;
        end else begin
            xb_cs    <= next_cs;
            xb_addr  <= next_addr;
            xb_rd    <= next_rd;
            xb_wr    <= next_wr;
            xb_dout  <= next_dout;
            xb_doe_n <= next_doe_n;
            xp_rdata <= next_rdata;
            xp_ack   <= next_ack;
        end
    end

endmodule : error_status_and_doorbell

// ==== rtl/error_status_pkg.sv ====
// Constants shared by the error status and doorbell logic.
// Assumes the includer runs on one controller clock.
package error_status_pkg;

    // Expansion ports: connectors, address lines and port width.
    localparam int XP_DATA_W  = 16;
    localparam int XP_ADDR_W  = 3;
    localparam int XP_CONN_N  = 2;
    localparam int XP_PORT_W  = XP_ADDR_W + 1;

    // Error status buffer byte offsets.
    localparam logic [3:0] HARD_ERROR_WORD_OFS = 4'h0;
    localparam logic [3:0] SOFT_ERROR_BYTE_OFS = 4'h2;

    // Hard error word bit positions.
    localparam int HE_RAM      = 3;
    localparam int HE_ROM      = 4;
    localparam int HE_SEEK_BSY = 5;
    localparam int HE_FORMAT   = 6;
    localparam int HE_EOM      = 7;
    localparam int HE_SECSIZE  = 8;
    localparam int HE_DIAG     = 9;
    localparam int HE_NO_INDEX = 10;
    localparam int HE_BAD_CMD  = 11;
    localparam int HE_NO_SECT  = 12;
    localparam int HE_BAD_ADDR = 13;
    localparam int HE_NOT_RDY  = 14;
    localparam int HE_WPROT    = 15;

    // Soft error byte bit positions.
    localparam int SE_DATA_ECC = 3;
    localparam int SE_ID_ECC   = 4;
    localparam int SE_DRIVE    = 5;
    localparam int SE_CYL_MIS  = 6;
    localparam int SE_SEEK     = 7;

    // Posted operation status: uncorrectable marker.
    localparam int OS_UNCORR = 6;

    // Reset values.
    localparam logic [15:0] HARD_RESET = 16'h0000;
    localparam logic [7:0]  SOFT_RESET = 8'h00;
    localparam logic [7:0]  BYTE_ZERO  = 8'h00;

    // Doorbell values and channel control byte 0 code.
    localparam logic [7:0] WAKE_CLEAR_IRQ = 8'h00;
    localparam logic [7:0] WAKE_START     = 8'h01;
    localparam logic [7:0] CCB_HOST_PROG  = 8'h03;

    // Function codes.
    localparam logic [7:0] FUNC_XFER_STATUS   = 8'h01;
    localparam logic [7:0] FUNC_EXP_TRANSFER  = 8'h0d;
    localparam logic [7:0] FUNC_LAST_FIRMWARE = 8'h0f;
    localparam logic [7:0] FUNC_RUN_RESIDENT  = 8'h10;

    // Controller activity.
    typedef enum logic [1:0] {
        MODE_IDLE,
        MODE_FIRMWARE,
        MODE_HOST_PROG,
        MODE_RESIDENT
    } run_mode_t;

endpackage : error_status_pkg

// ==== sim/error_status_chk.sv ====
// Checker for the error status and doorbell block, watching top-level ports only.
// Assumes one clock domain and the package constants of error_status_pkg.
`timescale 1ns/1ps

module error_status_chk
    import error_status_pkg::*;
(
    // Clock and reset.
    input wire logic        clock,
    input wire logic        rstn,
    // Host side inputs.
    input wire logic        wake_wr,
    input wire logic [7:0]  wake_data,
    input wire logic [7:0]  ccb_byte0,
    input wire logic        cmd_valid,
    input wire logic [7:0]  cmd_func,
    input wire logic        cmd_done,
    input wire logic        ram_fault,
    // Design outputs.
    input wire logic [15:0] hard_error_word,
    input wire logic [7:0]  soft_error_byte,
    input wire logic        host_irq,
    input run_mode_t        run_mode,
    input wire logic        fetch_host_program,
    input wire logic        params_in_invocation,
    input wire logic        start_resident,
    input wire logic [1:0]  xb_cs,
    input wire logic        xb_rd,
    input wire logic        xb_wr,
    input wire logic        xb_doe_n,
    input wire logic        xp_ack
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    // Most rules below tie an output to the input event one cycle earlier; reserved_zero_a, drive_oe_a and the select check of xp_ack_a check within one cycle.
    reserved_zero_a: assert property (hard_error_word[2:0] == 3'h0
        && soft_error_byte[2:0] == 3'h0) else $error("reserved status bits not zero");
    ram_bit_a: assert property (ram_fault |=> hard_error_word[HE_RAM])
        else $error("ram fault bit not set");
    clear_ram_a: assert property (cmd_valid && cmd_func != FUNC_XFER_STATUS && !ram_fault
        |=> !hard_error_word[HE_RAM]) else $error("new command did not clear errors");
    status_keep_a: assert property (cmd_valid && cmd_func == FUNC_XFER_STATUS
        |=> (hard_error_word & $past(hard_error_word)) == $past(hard_error_word))
        else $error("status transfer cleared errors");
    bad_cmd_a: assert property (cmd_valid && cmd_func > 8'h10
        |=> hard_error_word[HE_BAD_CMD]) else $error("invalid command not flagged");
    irq_drop_a: assert property (wake_wr && wake_data == 8'h00 && !cmd_done |=> !host_irq)
        else $error("interrupt not dropped");
    host_start_a: assert property (wake_wr && wake_data == 8'h01
        && run_mode == MODE_IDLE && ccb_byte0 == 8'h03 && !cmd_done
        |=> fetch_host_program && params_in_invocation && run_mode == MODE_HOST_PROG)
        else $error("host program start wrong");
    resident_go_a: assert property (run_mode == MODE_FIRMWARE && cmd_valid && !cmd_done
        && cmd_func == FUNC_RUN_RESIDENT |=> start_resident ##1 !start_resident)
        else $error("resident routine not started");
    xp_ack_a: assert property ((xb_rd || xb_wr) |-> $onehot(xb_cs) ##1 xp_ack)
        else $error("expansion strobe without select or ack");
    drive_oe_a: assert property (xb_wr |-> !xb_doe_n && !xb_rd)
        else $error("write data not driven");

    // Main scenarios.
    host_start_c: cover property (fetch_host_program);
    resident_c: cover property (start_resident);
    xp_write_c: cover property (xb_wr ##1 xp_ack);
endmodule : error_status_chk

bind error_status_and_doorbell error_status_chk chk (.clock(clock), .rstn(rstn),
    .wake_wr(wake_wr), .wake_data(wake_data), .ccb_byte0(ccb_byte0), .cmd_valid(cmd_valid),
    .cmd_func(cmd_func), .cmd_done(cmd_done), .ram_fault(ram_fault),
    .hard_error_word(hard_error_word), .soft_error_byte(soft_error_byte), .host_irq(host_irq),
    .run_mode(run_mode), .fetch_host_program(fetch_host_program),
    .params_in_invocation(params_in_invocation), .start_resident(start_resident),
    .xb_cs(xb_cs), .xb_rd(xb_rd), .xb_wr(xb_wr), .xb_doe_n(xb_doe_n), .xp_ack(xp_ack));

// ==== sim/tb.sv ====
// Self-checking bench for the error status and doorbell block.
// Assumes the checker is bound in and the port model answers the expansion pins.
`timescale 1ns/1ps

module tb;
    import error_status_pkg::*;
    localparam int CMD = 0, WAKE = 1, DONE = 2, CCB = 3, FLT = 4;
    logic clock = 1'b0, rstn = 1'b0, wake_wr = 1'b0, cmd_valid = 1'b0, cmd_done = 1'b0;
    logic cmd_uncorrectable = 1'b0, xp_req = 1'b0, xp_write = 1'b0;
    logic [7:0] wake_data = 8'h00, ccb_byte0 = 8'h00, cmd_func = 8'h00, op_status, soft_error_byte;
    logic [21:0] flt = '0;
    logic [3:0] xp_port = 4'h0;
    logic [15:0] xp_wdata = 16'h0000, hard_error_word, xp_rdata, xb_dout, xb_din, q;
    logic host_irq, fetch_invocation, fetch_host_program, params_in_invocation, start_resident;
    logic xp_ack, xb_rd, xb_wr, xb_doe_n;
    logic [1:0] xb_cs;
    logic [2:0] xb_addr;
    run_mode_t run_mode;
    int err_total = 0, n_checks = 0;
    int hb [22] = '{HE_RAM, HE_ROM, HE_SEEK_BSY, -1, -1, HE_FORMAT, HE_EOM, HE_SECSIZE, HE_DIAG,
        HE_NO_INDEX, HE_NO_SECT, HE_BAD_ADDR, HE_NOT_RDY, HE_WPROT, -1, -1, -1, -1, -1, -1, -1, -1};
    int sb [22] = '{-1, -1, -1, -1, -1, -1, -1, -1, -1, -1, -1, -1, -1, -1, 3, 4, 5, 5, 5, 5, 6, 7};
    logic [3:0] ports [4] = '{4'h0, 4'hf, 4'h8, 4'h7};
    logic [15:0] words [4] = '{16'ha5c3, 16'h3c5a, 16'h0ff0, 16'hf00f};

    error_status_and_doorbell dut (.clock(clock), .rstn(rstn), .wake_wr(wake_wr),
        .wake_data(wake_data), .ccb_byte0(ccb_byte0), .cmd_valid(cmd_valid), .cmd_func(cmd_func),
        .cmd_done(cmd_done), .cmd_uncorrectable(cmd_uncorrectable), .ram_fault(flt[0]),
        .rom_fault(flt[1]), .seek_underway_req(flt[2]), .spare_flag(flt[3]),
        .defective_spare_flag(flt[4]), .unassigned_spare_access(flt[5]), .end_of_media(flt[6]),
        .sector_size_mismatch(flt[7]), .diag_fault(flt[8]), .no_index(flt[9]),
        .sector_not_found(flt[10]), .bad_disk_address(flt[11]), .unit_not_ready(flt[12]),
        .write_protected_write(flt[13]), .data_field_code_err(flt[14]),
        .id_field_code_err(flt[15]), .rw_fault(flt[16]), .positioner_fault(flt[17]),
        .power_fault(flt[18]), .speed_fault(flt[19]), .cylinder_miscompare(flt[20]),
        .seek_failure(flt[21]), .hard_error_word(hard_error_word),
        .soft_error_byte(soft_error_byte), .op_status(op_status), .host_irq(host_irq),
        .run_mode(run_mode), .fetch_invocation(fetch_invocation),
        .fetch_host_program(fetch_host_program), .params_in_invocation(params_in_invocation),
        .start_resident(start_resident), .xp_req(xp_req), .xp_write(xp_write),
        .xp_port(xp_port), .xp_wdata(xp_wdata), .xp_rdata(xp_rdata), .xp_ack(xp_ack),
        .xb_cs(xb_cs), .xb_addr(xb_addr), .xb_rd(xb_rd), .xb_wr(xb_wr), .xb_dout(xb_dout),
        .xb_doe_n(xb_doe_n), .xb_din(xb_din));
    xp_port_model peer (.clock(clock), .xb_cs(xb_cs), .xb_addr(xb_addr), .xb_rd(xb_rd),
        .xb_wr(xb_wr), .xb_dout(xb_dout), .xb_din(xb_din));

    // Free-running 125 MHz clock.
    always #4 clock = ~clock;

    // Prints the counts and the verdict, then ends the run.
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : wrap_up

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // One-cycle event of kind k, except CCB, which keeps its value; returns mid-cycle after the answering edge.
    task automatic ev(input int k, input logic [21:0] v);
        @(posedge clock);
        case (k)
            CMD: begin cmd_valid <= 1'b1; cmd_func <= v[7:0]; end
            WAKE: begin wake_wr <= 1'b1; wake_data <= v[7:0]; end
            DONE: begin cmd_done <= 1'b1; cmd_uncorrectable <= v[0]; end
            CCB: ccb_byte0 <= v[7:0];
            default: flt <= v;
        endcase
        @(posedge clock);
        {cmd_valid, wake_wr, cmd_done} <= 3'b000;
        flt <= '0;
        @(negedge clock);
    endtask : ev

    // Expansion access: request held until the edge at which ack is seen high.
    task automatic xp(input logic wr, input logic [3:0] p, input logic [15:0] d);
        int i;
        @(posedge clock);
        xp_req <= 1'b1;
        xp_write <= wr;
        xp_port <= p;
        xp_wdata <= d;
        @(posedge clock);
        #1 chk("xb_cs", {14'h0, p[3], ~p[3]}, {14'h0, xb_cs});
        chk("xb_addr", {13'h0, p[2:0]}, {13'h0, xb_addr});
        chk("xb strobes", {13'h0, ~wr, wr, ~wr}, {13'h0, xb_rd, xb_wr, xb_doe_n});
        for (i = 0; i < 8; i++) begin
            @(posedge clock);
            if (xp_ack === 1'b1) break;
        end
        q = xp_rdata;
        xp_req <= 1'b0;
        if (i == 8) begin
            err_total++;
            $display("CHECK FAILED xp_ack expected 1 seen 0");
            wrap_up();
        end
    endtask : xp

    // Main sequence: reset, every fault source, commands, launch modes, expansion ports.
    initial begin
        logic [15:0] eh;
        logic [7:0] es;
        repeat (4) @(posedge clock);
        rstn <= 1'b1;
        @(negedge clock);
        chk("hard reset", HARD_RESET, hard_error_word);
        chk("doe_n reset", 16'h0001, {15'h0, xb_doe_n});
        for (int i = 0; i < 22; i++) begin
            eh = 16'h0000;
            es = 8'h00;
            if (hb[i] >= 0) eh[hb[i]] = 1'b1;
            if (sb[i] >= 0) es[sb[i]] = 1'b1;
            ev(FLT, 22'h1 << i);
            chk("hard", eh, hard_error_word);
            chk("soft", {8'h0, es}, {8'h0, soft_error_byte});
            ev(CMD, FUNC_XFER_STATUS);
            chk("hard kept", eh, hard_error_word);
            ev(CMD, 8'h02);
            chk("hard cleared", 16'h0000, hard_error_word | {8'h0, soft_error_byte});
        end
        ev(FLT, 22'h18);
        chk("both spare flags", 16'h0040, hard_error_word);
        ev(CMD, 8'h11);
        chk("invalid code", 16'h0800, hard_error_word);
        ev(CMD, FUNC_LAST_FIRMWARE);
        chk("valid code", 16'h0000, hard_error_word);
        ev(DONE, 22'h1);
        chk("op_status", 16'h0040, {8'h0, op_status});
        chk("irq set", 16'h0001, {15'h0, host_irq});
        ev(WAKE, WAKE_CLEAR_IRQ);
        chk("irq cleared", 16'h0000, {15'h0, host_irq});
        ev(DONE, 22'h0);
        chk("op_status", 16'h0000, {8'h0, op_status});
        ev(CCB, CCB_HOST_PROG);
        ev(WAKE, WAKE_START);
        chk("host mode", {14'h0, MODE_HOST_PROG}, {14'h0, run_mode});
        chk("fetch host", 16'h0001, {15'h0, fetch_host_program});
        chk("params set", 16'h0001, {15'h0, params_in_invocation});
        ev(WAKE, WAKE_START);
        chk("restart ignored", {14'h0, MODE_HOST_PROG}, {14'h0, run_mode});
        ev(DONE, 22'h0);
        ev(CCB, 22'h0);
        ev(WAKE, WAKE_START);
        chk("firmware mode", {14'h0, MODE_FIRMWARE}, {14'h0, run_mode});
        chk("fetch inv", 16'h0001, {15'h0, fetch_invocation});
        chk("params clear", 16'h0000, {15'h0, params_in_invocation});
        ev(CMD, FUNC_RUN_RESIDENT);
        chk("resident", {13'h0, MODE_RESIDENT, 1'b1}, {13'h0, run_mode, start_resident});
        ev(DONE, 22'h0);
        ev(WAKE, 22'h02);
        chk("other wake value", {14'h0, MODE_IDLE}, {14'h0, run_mode});
        foreach (ports[i]) xp(1'b1, ports[i], words[i]);
        foreach (ports[i]) begin
            xp(1'b0, ports[i], 16'h0000);
            chk("xp read", words[i], q);
        end
        wrap_up();
    end
endmodule : tb

// ==== sim/xp_port_model.sv ====
// Peripheral on the expansion connectors: sixteen 16-bit ports, eight per connector.
// Assumes strobes last one clock cycle with chip select and address valid alongside.
`timescale 1ns/1ps

module xp_port_model (
    // Clock.
    input wire logic        clock,
    // Connector pins.
    input wire logic [1:0]  xb_cs,
    input wire logic [2:0]  xb_addr,
    input wire logic        xb_rd,
    input wire logic        xb_wr,
    input wire logic [15:0] xb_dout,
    output logic [15:0]     xb_din
);
    logic [15:0] mem [16];
    logic [15:0] last = 16'h0000;
    wire  [3:0]  idx = {xb_cs[1], xb_addr};

    // Store writes; remember the last value read so the released bus can show its inverse.
    always @(posedge clock) begin
        if (xb_wr) mem[idx] <= xb_dout;
        if (xb_rd) last <= mem[idx];
    end
    // The data lines carry no pull, so outside a read they show a changing value.
    assign xb_din = xb_rd ? mem[idx] : ~last;
endmodule : xp_port_model
